// file: shared/rar_pkg.sv
// Purpose: shared constants for the register-read command link
// Assumes: one system clock MCLK at 50 MHz
// Notes: register map offsets are byte addresses on the serial link
package rar_pkg;
  localparam logic [7:0] RAR_OPCODE = 8'h65;
  localparam int RAR_CLK_PERIOD_NS = 20;
  localparam int RAR_SCK_PERIOD_NS = 160;
  localparam int RAR_SCK_HALF_CYC = RAR_SCK_PERIOD_NS / (2 * RAR_CLK_PERIOD_NS);
  // Fields of volatile_config_reg_two and sector_protect_config_reg
  localparam int RAR_CFG_ALEN_BIT = 7;
  localparam int RAR_CFG_LAT_MSB = 3;
  localparam int RAR_SPC_PWD_BIT = 2;
  // Register map on the link
  localparam logic [31:0] RAR_A_SR1NV = 32'h0000_0000;
  localparam logic [31:0] RAR_A_CR1NV = 32'h0000_0002;
  localparam logic [31:0] RAR_A_CR2NV = 32'h0000_0003;
  localparam logic [31:0] RAR_A_CR3NV = 32'h0000_0004;
  localparam logic [31:0] RAR_A_CR4NV = 32'h0000_0005;
  localparam logic [31:0] RAR_A_NVDLR = 32'h0000_0010;
  localparam logic [31:0] RAR_A_PASS_LO = 32'h0000_0020;
  localparam logic [31:0] RAR_A_PASS_HI = 32'h0000_0027;
  localparam logic [31:0] RAR_A_SPC_LO = 32'h0000_0030;
  localparam logic [31:0] RAR_A_SPC_HI = 32'h0000_0031;
  localparam logic [31:0] RAR_A_STAT1_VOL = 32'h0080_0000;
  localparam logic [31:0] RAR_A_SR2V = 32'h0080_0001;
  localparam logic [31:0] RAR_A_CR1V = 32'h0080_0002;
  localparam logic [31:0] RAR_A_CFG2_VOL = 32'h0080_0003;
  localparam logic [31:0] RAR_A_CR3V = 32'h0080_0004;
  localparam logic [31:0] RAR_A_CR4V = 32'h0080_0005;
  localparam logic [31:0] RAR_A_VDLR = 32'h0080_0010;
  localparam logic [31:0] RAR_A_PPBL = 32'h0080_0040;
  localparam logic [7:0] RAR_INVALID_BYTE = 8'hFF;
  // Host controller registers on AHB-Lite
  localparam logic [7:0] RAR_R_CTRL = 8'h00;
  localparam logic [7:0] RAR_R_ADDR = 8'h04;
  localparam logic [7:0] RAR_R_STAT = 8'h08;
  localparam logic [7:0] RAR_R_DATA = 8'h0C;
  localparam int RAR_CTRL_START = 0;
  localparam int RAR_CTRL_FOUR = 1;
  localparam int RAR_CTRL_QUAD = 2;
  localparam int RAR_CTRL_LAT_LSB = 4;
  localparam int RAR_STAT_BUSY = 0;
  localparam int RAR_STAT_DONE = 1;
  localparam logic [7:0] RAR_CTRL_RST = 8'h00;
endpackage

// file: shared/rar_spi_if.sv
// Purpose: serial link between host controller and flash command handler
// Assumes: pull-up on every data line when nobody drives it
// Notes: line levels are resolved here from the two output enables
`timescale 1ns/1ps
interface rar_spi_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_out;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_out;
  logic [3:0] d_io_oe;
  logic [3:0] io;
  genvar i;
  for (i = 0; i < 4; i++) begin : g_line
    assign io[i] = d_io_oe[i] ? d_io_out[i] : (h_io_oe[i] ? h_io_out[i] : 1'b1);
  end
  modport host (output sck, output cs_n, output h_io_out, output h_io_oe, input io);
  modport device (input sck, input cs_n, output d_io_out, output d_io_oe, input io);
endinterface

// file: logic/rar_device.sv
// Purpose: flash-side handler of the generic register-read command
// Assumes: SPI mode 0, link pins sampled by MCLK, SCK well below MCLK/6
// Notes: register contents come from outside through REG_ADDR / REG_DATA
// How it works
// - Opcode 65h starts generic register read
// - Three or four address bytes per config
// - Latency cycles from config field, then data
// - Same byte repeats while clocking continues
// - Undefined addresses return arbitrary data
// - Command accepted during embedded operations
// - Host avoids window registers via this command
// - Password locations read invalid in password mode
// - Map covers volatile and non-volatile registers
// - Address MSB is bit 23 or 31
// - Quad mode takes opcode on four lines
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module rar_device
  import rar_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  rar_spi_if.device spi,
  input wire logic [7:0] CFG_REG_TWO,
  input wire logic [7:0] SPC_CFG,
  input wire logic QUAD_MODE,
  output logic [31:0] REG_ADDR,
  output logic REG_RD,
  input wire logic [7:0] REG_DATA,
  output logic CMD_ACTIVE
);
  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADR = 3'b001,
    ST_DUM = 3'b010,
    ST_DAT = 3'b011,
    ST_IGN = 3'b100
  } rar_dst_t;

  rar_dst_t state_r;
  logic [2:0] sck_s;
  logic [1:0] cs_s;
  logic [3:0] io_s0;
  logic [3:0] io_s1;
  logic rise;
  logic fall;
  logic four;
  logic [3:0] lat;
  logic [5:0] cnt_r;
  logic [5:0] opc_last;
  logic [5:0] adr_last;
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic [31:0] addr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic first_r;
  logic [3:0] io_out_r;
  logic [3:0] io_oe_r;
  logic pwd_hit;
  logic [7:0] byte_sel;
  logic dat_go;

  // Link pins cross into MCLK through two flops before use
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_s <= 3'b000;
      cs_s <= 2'b11;
    end else begin
      sck_s <= {sck_s[1:0], spi.sck};
      cs_s <= {cs_s[0], spi.cs_n};
    end
  end

  // Data lines idle high through the pull-ups, so these flops reset high
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      io_s0 <= 4'hF;
      io_s1 <= 4'hF;
    end else begin
      io_s0 <= spi.io;
      io_s1 <= io_s0;
    end
  end

  assign rise = sck_s[1] & ~sck_s[2];
  assign fall = ~sck_s[1] & sck_s[2];
  assign four = CFG_REG_TWO[RAR_CFG_ALEN_BIT];
  assign lat = CFG_REG_TWO[RAR_CFG_LAT_MSB:0];
  assign opc_last = QUAD_MODE ? 6'h01 : 6'h07;
  assign adr_last = QUAD_MODE ? (four ? 6'h07 : 6'h05) : (four ? 6'h1F : 6'h17);
  assign sh_nxt = QUAD_MODE ? {sh_r[27:0], io_s1} : {sh_r[30:0], io_s1[0]};
  assign addr_nxt = four ? sh_nxt : {8'h00, sh_nxt[23:0]};

  // Password bytes are masked once password mode is chosen; other bytes pass as given
  assign pwd_hit = (REG_ADDR >= RAR_A_PASS_LO) && (REG_ADDR <= RAR_A_PASS_HI);
  assign byte_sel = (pwd_hit && !SPC_CFG[RAR_SPC_PWD_BIT]) ? RAR_INVALID_BYTE : REG_DATA;

  // Command sequencing on SCK rising edges; no busy input, so embedded work never blocks it
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_OPC;
      cnt_r <= 6'h00;
      sh_r <= 32'h0000_0000;
    end else begin
      if (cs_s[1]) begin
        state_r <= ST_OPC;
        cnt_r <= 6'h00;
      end else if (rise) begin
        unique case (state_r)
          ST_OPC: begin
            sh_r <= sh_nxt;
            if (cnt_r == opc_last) begin
              cnt_r <= 6'h00;
              state_r <= (sh_nxt[7:0] == RAR_OPCODE) ? ST_ADR : ST_IGN;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
          ST_ADR: begin
            sh_r <= sh_nxt;
            if (cnt_r == adr_last) begin
              cnt_r <= 6'h00;
              state_r <= (lat == 4'h0) ? ST_DAT : ST_DUM;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
          ST_DUM: begin
            if (cnt_r == {2'b00, lat - 4'h1}) begin
              cnt_r <= 6'h00;
              state_r <= ST_DAT;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
          ST_DAT: begin
            state_r <= ST_DAT;
          end
          ST_IGN: begin
            state_r <= ST_IGN;
          end
          default: begin
            state_r <= ST_OPC;
          end
        endcase
      end
    end
  end

  // Address capture and read strobe; the address then holds until the next command
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_ADDR <= 32'h0000_0000;
      REG_RD <= 1'b0;
    end else begin
      REG_RD <= 1'b0;
      if (!cs_s[1] && rise && (state_r == ST_ADR) && (cnt_r == adr_last)) begin
        REG_ADDR <= addr_nxt;
        REG_RD <= 1'b1;
      end
    end
  end

  // Last address or dummy rise: the first data bit goes out on the following fall
  assign dat_go = rise && (((state_r == ST_ADR) && (cnt_r == adr_last) && (lat == 4'h0))
                  || ((state_r == ST_DUM) && (cnt_r == {2'b00, lat - 4'h1})));

  // Rotating the byte rather than refetching keeps the address fixed for the whole command
  always_comb begin
    if (first_r) begin
      tx_nxt = byte_sel;
    end else if (QUAD_MODE) begin
      tx_nxt = {tx_r[3:0], tx_r[7:4]};
    end else begin
      tx_nxt = {tx_r[6:0], tx_r[7]};
    end
  end

  // Output shifting on SCK falling edges
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_r <= 8'h00;
      first_r <= 1'b0;
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (cs_s[1]) begin
      first_r <= 1'b0;
      io_oe_r <= 4'h0;
    end else if (dat_go) begin
      first_r <= 1'b1;
    end else if (fall && (state_r == ST_DAT)) begin
      tx_r <= tx_nxt;
      first_r <= 1'b0;
      io_out_r <= QUAD_MODE ? tx_nxt[7:4] : {2'b00, tx_nxt[7], 1'b0};
      io_oe_r <= QUAD_MODE ? 4'hF : 4'h2;
    end
  end

  assign spi.d_io_out = io_out_r;
  assign spi.d_io_oe = io_oe_r;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CMD_ACTIVE <= 1'b0;
    end else begin
      CMD_ACTIVE <= !cs_s[1] && (state_r != ST_OPC) && (state_r != ST_IGN);
    end
  end
endmodule

// file: logic/rar_host.sv
// Purpose: host controller issuing generic register reads, steered over AHB-Lite
// Assumes: framing settings match the device configuration
// Notes: returns the first two data bytes so repetition can be observed
`timescale 1ns/1ps
module rar_host
  import rar_pkg::*;
#(
  parameter int HALF_DIV = RAR_SCK_HALF_CYC
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  rar_spi_if.host spi
);
  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_RUN = 1'b1
  } rar_hst_t;

  rar_hst_t state_r;
  logic pend_r;
  logic pend_wr_r;
  logic [7:0] pend_a_r;
  logic [7:0] ctrl_r;
  logic [31:0] addr_r;
  logic done_r;
  logic [15:0] rx_r;
  logic [1:0] io_s;
  logic [3:0] io_s0;
  logic [3:0] io_s1;
  logic [7:0] div_r;
  logic tick;
  logic sck_r;
  logic cs_n_r;
  logic [6:0] cyc_r;
  logic [39:0] tx_r;
  logic [39:0] tx_nxt;
  logic [3:0] io_out_r;
  logic [3:0] io_oe_r;
  logic quad;
  logic [6:0] c_cyc;
  logic [6:0] d_end;
  logic [6:0] r_end;
  logic start;
  logic finish;
  logic wr_go;

  assign quad = ctrl_r[RAR_CTRL_QUAD];
  assign c_cyc = quad ? (ctrl_r[RAR_CTRL_FOUR] ? 7'h0A : 7'h08) : (ctrl_r[RAR_CTRL_FOUR] ? 7'h28 : 7'h20);
  assign d_end = c_cyc + {3'b000, ctrl_r[RAR_CTRL_LAT_LSB +: 4]};
  assign r_end = d_end + (quad ? 7'h04 : 7'h10);
  assign wr_go = pend_r && pend_wr_r;
  assign start = wr_go && (pend_a_r == RAR_R_CTRL) && HWDATA[RAR_CTRL_START] && (state_r == HS_IDLE);
  assign tick = (div_r == 8'(HALF_DIV - 1));
  assign finish = (state_r == HS_RUN) && tick && sck_r && (cyc_r == r_end - 7'h01);

  // AHB-Lite slave: one wait state so read data leaves a flop
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_a_r <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      HREADYOUT <= 1'b1;
      if (!pend_wr_r) begin
        unique case (pend_a_r)
          RAR_R_CTRL: HRDATA <= {24'h000000, ctrl_r};
          RAR_R_ADDR: HRDATA <= addr_r;
          RAR_R_STAT: HRDATA <= {30'h0, done_r, state_r == HS_RUN};
          RAR_R_DATA: HRDATA <= {16'h0000, rx_r};
          default: HRDATA <= 32'h0000_0000;
        endcase
      end
    end else if (HSEL && HREADY && HTRANS[1]) begin
      pend_r <= 1'b1;
      pend_wr_r <= HWRITE;
      pend_a_r <= {HADDR[7:2], 2'b00};
      HREADYOUT <= 1'b0;
    end
  end

  // Control registers; settings are frozen while a command runs
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= RAR_CTRL_RST;
      addr_r <= 32'h0000_0000;
    end else if (wr_go && (state_r == HS_IDLE)) begin
      if (pend_a_r == RAR_R_CTRL) begin
        ctrl_r <= {HWDATA[7:1], 1'b0};
      end
      if (pend_a_r == RAR_R_ADDR) begin
        addr_r <= HWDATA;
      end
    end
  end

  // Done is sticky; a finish in the clearing cycle wins
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r <= 1'b0;
    end else begin
      done_r <= finish || (done_r && !(wr_go && (pend_a_r == RAR_R_STAT) && HWDATA[RAR_STAT_DONE]));
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      io_s0 <= 4'hF;
      io_s1 <= 4'hF;
    end else begin
      io_s0 <= spi.io;
      io_s1 <= io_s0;
    end
  end
  assign io_s = quad ? 2'b00 : 2'b01;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 8'h00;
    end else if ((state_r == HS_IDLE) || tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  assign tx_nxt = quad ? {tx_r[35:0], 4'h0} : {tx_r[38:0], 1'b0};

  // Serial engine: SCK from the divider, drive after falling edge, sample late in the high phase
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= HS_IDLE;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      cyc_r <= 7'h00;
      tx_r <= 40'h00_0000_0000;
      rx_r <= 16'h0000;
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else if (start) begin
      state_r <= HS_RUN;
      cs_n_r <= 1'b0;
      cyc_r <= 7'h00;
      tx_r <= HWDATA[RAR_CTRL_FOUR] ? {RAR_OPCODE, addr_r} : {RAR_OPCODE, addr_r[23:0], 8'h00};
      io_out_r <= HWDATA[RAR_CTRL_QUAD] ? RAR_OPCODE[7:4] : {3'b000, RAR_OPCODE[7]};
      io_oe_r <= HWDATA[RAR_CTRL_QUAD] ? 4'hF : 4'h1;
    end else if ((state_r == HS_RUN) && tick) begin
      if (!sck_r) begin
        sck_r <= 1'b1;
      end else begin
        sck_r <= 1'b0;
        cyc_r <= cyc_r + 7'h01;
        tx_r <= tx_nxt;
        io_out_r <= quad ? tx_nxt[39:36] : {3'b000, tx_nxt[39]};
        if (cyc_r >= d_end) begin
          rx_r <= quad ? {rx_r[11:0], io_s1} : {rx_r[14:0], io_s1[io_s]};
        end
        if (cyc_r + 7'h01 >= c_cyc) begin
          io_oe_r <= 4'h0;
        end
        if (finish) begin
          state_r <= HS_IDLE;
          cs_n_r <= 1'b1;
        end
      end
    end
  end

  assign spi.sck = sck_r;
  assign spi.cs_n = cs_n_r;
  assign spi.h_io_out = io_out_r;
  assign spi.h_io_oe = io_oe_r;
endmodule

// file: verif/rar_link_props.sv
// Purpose: link assertions for the register-read command
// Assumes: mode 0 link, single or quad framing, HALF_DIV of 4
// Notes: opcode is rebuilt from io at each sampled SCK rise
`timescale 1ns/1ps
module rar_link_props
  import rar_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_oe,
  input wire logic [3:0] io
);
  logic sck_q;
  logic quad_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  // Mode is latched before the first rise so it outlives CS for the release checks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      quad_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end else begin
      sck_q <= sck;
      if (!cs_n && cnt_r == 4'h0) begin
        quad_r <= h_io_oe[1];
      end
      if (cs_n) begin
        cnt_r <= 4'h0;
      end else if (sck && !sck_q) begin
        cnt_r <= (cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1;
        sh_r <= quad_r ? {sh_r[3:0], io} : {sh_r[6:0], io[0]};
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $fell(cs_n);
  endsequence
  sequence s_op_done;
    $changed(cnt_r) && cnt_r == (quad_r ? 4'h2 : 4'h8);
  endsequence
  chk_opcode_sent: assert property (s_op_done |-> sh_r == RAR_OPCODE)
    else $error("opcode on link is wrong");
  chk_start_low: assert property (s_start |-> (!sck) [*3])
    else $error("clock not low at frame start");
  chk_idle_quiet: assert property (cs_n |-> !sck && h_io_oe == 4'h0)
    else $error("host active outside frame");
  chk_sck_high: assert property ($rose(sck) |=> sck [*3])
    else $error("clock high phase too short");
  chk_no_clash: assert property (|d_io_oe |-> h_io_oe == 4'h0)
    else $error("both ends drive the lines");
  chk_dev_release: assert property ($rose(cs_n) |-> ##[1:6] d_io_oe == 4'h0)
    else $error("device holds lines after frame");
  chk_dev_idle: assert property (cs_n [*8] |-> d_io_oe == 4'h0)
    else $error("device drives while deselected");
  chk_single_out: assert property (|d_io_oe && !quad_r |-> d_io_oe == 4'h2)
    else $error("single mode data not on io1 only");
  chk_quad_out: assert property (|d_io_oe && quad_r |-> d_io_oe == 4'hF)
    else $error("quad mode data not on all lines");
endmodule

// file: verif/spi_flash_read_any_register_tb.sv
// Purpose: end-to-end bench, host controller against flash handler
// Assumes: bench register file answers REG_ADDR within one cycle
// Notes: each test reads one register through the host's AHB-Lite registers
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module spi_flash_read_any_register_tb;
  import rar_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] cfg_two = 8'h00;
  logic [7:0] spc_cfg = 8'h04;
  logic quad_mode = 1'b0;
  logic [31:0] reg_addr;
  logic reg_rd;
  logic [7:0] reg_data;
  logic cmd_active;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_rd = 0;
  // Mode fields per test: four-byte, quad, protect bit two, latency
  logic [6:0] t_mode [7] = '{7'h18, 7'h5F, 7'h33, 7'h60, 7'h11, 7'h12, 7'h10};
  // Plain registers, password bytes and undefined addresses are read; the window registers need their own commands
  logic [31:0] t_addr [7] = '{RAR_A_CFG2_VOL, RAR_A_NVDLR | 32'h5A00_0000, RAR_A_VDLR, RAR_A_PASS_HI,
    RAR_A_PASS_LO, 32'hAB12_3456, RAR_A_STAT1_VOL};
  rar_spi_if rar_spi_if_inst ();
  rar_host rar_host_inst (.MCLK(mclk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
    .HRESP(hresp), .HRDATA(hrdata), .spi(rar_spi_if_inst));
  rar_device rar_device_inst (.MCLK(mclk), .RST_N(rst_n), .spi(rar_spi_if_inst), .CFG_REG_TWO(cfg_two),
    .SPC_CFG(spc_cfg), .QUAD_MODE(quad_mode), .REG_ADDR(reg_addr), .REG_RD(reg_rd),
    .REG_DATA(reg_data), .CMD_ACTIVE(cmd_active));
  rar_link_props rar_link_props_inst (.mclk(mclk), .rst_n(rst_n), .sck(rar_spi_if_inst.sck),
    .cs_n(rar_spi_if_inst.cs_n), .h_io_oe(rar_spi_if_inst.h_io_oe), .d_io_oe(rar_spi_if_inst.d_io_oe),
    .io(rar_spi_if_inst.io));
  always #10 mclk = ~mclk;
  // Register contents depend on address bits 31:24 and 7:0 so a wrong address there shows in the data
  function automatic logic [7:0] map(input logic [31:0] a);
    map = a[7:0] ^ a[31:24] ^ 8'h3C;
  endfunction
  assign reg_data = map(reg_addr);
  always @(posedge mclk) begin
    if (reg_rd === 1'b1) begin
      n_rd++;
    end
  end
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    logic [31:0] rd;
    logic [31:0] a;
    logic [31:0] ea;
    logic [6:0] m;
    logic [7:0] e;
    logic seen;
    int n;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    ahb(1'b0, 8'h10, 32'h0, rd);
    `CHK(rd, 32'h0, "unmapped read")
    `CHK(hresp, 1'b0, "response code")
    for (int i = 0; i < 7; i++) begin
      m = t_mode[i];
      a = t_addr[i];
      ea = m[6] ? a : {8'h00, a[23:0]};
      e = (!m[4] && ea >= RAR_A_PASS_LO && ea <= RAR_A_PASS_HI) ? RAR_INVALID_BYTE : map(ea);
      cfg_two <= {m[6], 3'b000, m[3:0]};
      quad_mode <= m[5];
      spc_cfg <= {5'h00, m[4], 2'b00};
      ahb(1'b1, RAR_R_ADDR, a, rd);
      ahb(1'b1, RAR_R_CTRL, {24'h0, m[3:0], 1'b0, m[5], m[6], 1'b1}, rd);
      // Busy controller must ignore a new address mid-command
      ahb(1'b1, RAR_R_ADDR, ~a, rd);
      n = 0;
      seen = 1'b0;
      do begin
        ahb(1'b0, RAR_R_STAT, 32'h0, rd);
        if (cmd_active === 1'b1) begin
          seen = 1'b1;
        end
        n++;
      end while (rd[RAR_STAT_DONE] !== 1'b1 && n < 500);
      `CHK(rd[1:0], 2'b10, "status at end")
      `CHK(seen, 1'b1, "command never active")
      ahb(1'b0, RAR_R_DATA, 32'h0, rd);
      `CHK(rd[15:0], {e, e}, "returned byte")
      // The flag drops three cycles after select rises, so it is looked at only after one more access
      `CHK(cmd_active, 1'b0, "command still active")
      `CHK(reg_addr, ea, "captured address")
      `CHK(n_rd, i + 1, "register read count")
      ahb(1'b0, RAR_R_ADDR, 32'h0, rd);
      `CHK(rd, a, "address changed while busy")
      ahb(1'b1, RAR_R_STAT, 32'h2, rd);
      ahb(1'b0, RAR_R_STAT, 32'h0, rd);
      `CHK(rd[1:0], 2'b00, "done cleared")
      $display("test %0d done", i);
    end
    wrap_up;
  end
endmodule
